// *** rtl/wit_timer.sv ***
/*
   Watchdog / interval timer top: counter, control/status register,
   overflow actions, clock settling count and clock output pin control.
   Assumes rst is the power-on reset from the external pin; internal
   resets requested here are applied elsewhere and never reach rst.
*/
module wit_timer
   import wit_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire wit_bus_req_type bus_req,
   output logic [7:0]           bus_rdata,
   output logic                 bus_ack,
   input  wire logic [2:0]      clock_mode_pin,
   input  wire logic            clock_out_enable,
   input  wire logic            settle_req,
   input  wire logic            clock_out_pin_i,
   output logic                 clock_out_pin_o,
   output logic                 clock_out_pin_oe_n,
   output logic                 por_req,
   output logic                 manual_req,
   output logic                 interval_irq,
   output logic                 clock_restart,
   output logic                 internal_clock_stop
);
   import wit_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [7:0]     count_q;
   logic [7:0]     count_d;
   logic [7:0]     csr_q;
   logic [7:0]     csr_d;
   wit_settle_type settle_q;
   wit_settle_type settle_d;
   logic           por_q;
   logic           por_d;
   logic           manual_q;
   logic           manual_d;
   logic           irq_q;
   logic           irq_d;
   logic           restart_q;
   logic           restart_d;
   logic           stop_q;
   logic           stop_d;
   logic           ckout_q;
   logic           ckout_d;
   logic           oe_n_q;
   logic           oe_n_d;
   logic [2:0]     mode_s1_q;
   logic [2:0]     mode_s2_q;
   logic [2:0]     mode_s3_q;
   logic [2:0]     mode_q;
   logic [2:0]     mode_d;
   logic           tick;
   logic           wr_count;
   logic           wr_csr;
   logic [7:0]     wr_data;
   logic           counting;
   logic           settling;
   logic           overflow;
   logic           fixable;
   logic           pin_unused;

   // -----------------------------------------------------------------
   // Submodules
   // -----------------------------------------------------------------
   wit_prescaler u_prescaler (
      .clock  (clock),
      .rst    (rst),
      .select (csr_q[`WIT_CKS_HI:`WIT_CKS_LO]),
      .tick   (tick)
   );

   wit_bus_port u_bus_port (
      .clock       (clock),
      .rst         (rst),
      .bus_req     (bus_req),
      .count_val   (count_q),
      .csr_val     (csr_q),
      .wr_count_q  (wr_count),
      .wr_csr_q    (wr_csr),
      .wr_data_q   (wr_data),
      .bus_rdata_q (bus_rdata),
      .bus_ack_q   (bus_ack)
   );

   // -----------------------------------------------------------------
   // Counter and overflow
   // -----------------------------------------------------------------
   always_comb begin
      settling = (settle_q == WIT_SETTLE_COUNT);
      // Run bit counts only while settling is idle, so the two never mix
      counting = settling || (csr_q[`WIT_BIT_RUN] && (settle_q == WIT_SETTLE_IDLE));
      overflow = counting && tick && (count_q == `WIT_COUNT_MAX);
      count_d  = count_q;
      if (wr_count) begin
         count_d = wr_data;
      end else if (counting && tick) begin
         count_d = count_q + 8'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         count_q <= `WIT_COUNT_RESET;
      end else begin
         // Requested resets never reach the counter
         count_q <= count_d;
      end
   end

   // -----------------------------------------------------------------
   // Control/status register and overflow actions
   // -----------------------------------------------------------------
   always_comb begin
      csr_d    = csr_q;
      por_d    = 1'b0;
      manual_d = 1'b0;
      irq_d    = 1'b0;
      if (wr_csr) begin
         csr_d = wr_data;
      end
      // Flag set beats a same-cycle software clear
      if (overflow && !settling) begin
         if (csr_q[`WIT_BIT_MODE]) begin
            csr_d[`WIT_BIT_WATCHDOG_OVERFLOW_FLAG] = 1'b1;
            por_d                = !csr_q[`WIT_BIT_RSTKIND];
            manual_d             = csr_q[`WIT_BIT_RSTKIND];
         end else begin
            csr_d[`WIT_BIT_INTERVAL_OVERFLOW_FLAG] = 1'b1;
            irq_d                = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         csr_q    <= `WIT_CSR_RESET;
         por_q    <= 1'b0;
         manual_q <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         // Internal resets requested here leave the register alone
         csr_q    <= csr_d;
         por_q    <= por_d;
         manual_q <= manual_d;
         irq_q    <= irq_d;
      end
   end

   // -----------------------------------------------------------------
   // Clock settling sequence
   // -----------------------------------------------------------------
   always_comb begin
      settle_d  = settle_q;
      restart_d = 1'b0;
      stop_d    = stop_q;
      case (settle_q)
         WIT_SETTLE_IDLE: begin
            if (settle_req) begin
               // Stop output updates this edge; counting waits a cycle
               settle_d = WIT_SETTLE_ARM;
               stop_d   = 1'b1;
            end
         end
         WIT_SETTLE_ARM: begin
            settle_d = WIT_SETTLE_COUNT;
         end
         WIT_SETTLE_COUNT: begin
            if (overflow) begin
               // No flag, control register untouched
               settle_d  = WIT_SETTLE_IDLE;
               restart_d = 1'b1;
               stop_d    = 1'b0;
            end
         end
         default: begin
            settle_d = WIT_SETTLE_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         settle_q  <= WIT_SETTLE_IDLE;
         restart_q <= 1'b0;
         stop_q    <= 1'b0;
      end else begin
         settle_q  <= settle_d;
         restart_q <= restart_d;
         stop_q    <= stop_d;
      end
   end

   // -----------------------------------------------------------------
   // Clock output pin
   // -----------------------------------------------------------------
   always_comb begin
      pin_unused = clock_out_pin_i;
      mode_d     = (mode_s2_q == mode_s3_q) ? mode_s3_q : mode_q;
      fixable    = (mode_q == `WIT_CKMODE_3) || (mode_q == `WIT_CKMODE_4);
      // Enable low only freezes the pin in modes 3 and 4
      if (fixable && !clock_out_enable) begin
         ckout_d = 1'b0;
      end else begin
         ckout_d = ~ckout_q;
      end
      // Mode 7 turns the pin into an input
      oe_n_d = (mode_q == `WIT_CKMODE_IN);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ckout_q   <= 1'b0;
         oe_n_q    <= 1'b1;
         mode_s1_q <= `WIT_CKMODE_RESET;
         mode_s2_q <= `WIT_CKMODE_RESET;
         mode_s3_q <= `WIT_CKMODE_RESET;
         mode_q    <= `WIT_CKMODE_RESET;
      end else begin
         ckout_q   <= ckout_d;
         oe_n_q    <= oe_n_d;
         // Strap is asynchronous; only the second stage feeds the third
         mode_s1_q <= clock_mode_pin;
         mode_s2_q <= mode_s1_q;
         mode_s3_q <= mode_s2_q;
         mode_q    <= mode_d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign por_req             = por_q;
   assign manual_req          = manual_q;
   assign interval_irq        = irq_q;
   assign clock_restart       = restart_q;
   assign internal_clock_stop = stop_q;
   assign clock_out_pin_o     = ckout_q;
   assign clock_out_pin_oe_n  = oe_n_q;
endmodule : wit_timer

// *** rtl/wit_defines.svh ***
/*
   Constants of the watchdog / interval timer: register addresses, write keys,
   field positions, reset values and clock mode codes.
   Assumes inclusion by bare name from the timer's package and modules.
*/
`ifndef WIT_DEFINES_SVH
`define WIT_DEFINES_SVH


// -----------------------------------------------------------------
// Register map and keys
// -----------------------------------------------------------------
`define WIT_ADDR_COUNT   32'hffffff84
`define WIT_ADDR_CSR     32'h0fffff86
`define WIT_KEY_COUNT    8'h5a
`define WIT_KEY_CSR      8'ha5

// -----------------------------------------------------------------
// Control/status fields and reset values
// -----------------------------------------------------------------
`define WIT_BIT_RUN      7
`define WIT_BIT_MODE     6
`define WIT_BIT_RSTKIND  5
`define WIT_BIT_WATCHDOG_OVERFLOW_FLAG     4
`define WIT_BIT_INTERVAL_OVERFLOW_FLAG     3
`define WIT_CKS_HI       2
`define WIT_CKS_LO       0
`define WIT_COUNT_RESET  8'h00
`define WIT_CSR_RESET    8'h00
`define WIT_COUNT_MAX    8'hff

// -----------------------------------------------------------------
// Clock modes and prescaler
// -----------------------------------------------------------------
`define WIT_CKMODE_3     3'h3
`define WIT_CKMODE_4     3'h4
`define WIT_CKMODE_IN    3'h7
`define WIT_CKMODE_RESET 3'h0
`define WIT_PRE_RESET    12'h000

`endif

// *** rtl/wit_pkg.sv ***
/*
   Types shared by the watchdog / interval timer modules.
   Assumes the constants header is on the include path.
*/
package wit_pkg;
   `include "wit_defines.svh"

   typedef enum logic [1:0] {
      WIT_SIZE_BYTE,
      WIT_SIZE_WORD,
      WIT_SIZE_LONG
   } wit_size_type;

   typedef struct packed {
      logic         sel;
      logic         write;
      wit_size_type size;
      logic [31:0]  addr;
      logic [15:0]  wdata;
   } wit_bus_req_type;

   typedef enum logic [1:0] {
      WIT_SETTLE_IDLE,
      WIT_SETTLE_ARM,
      WIT_SETTLE_COUNT
   } wit_settle_type;
endpackage : wit_pkg

// *** rtl/wit_prescaler.sv ***
/*
   Free-running prescaler giving a one-cycle count tick at the selected ratio.
   Assumes the select field is only changed while the timer is stopped.
*/
module wit_prescaler
   import wit_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [2:0]  select,
   output logic             tick
);
   import wit_pkg::*;

   logic [11:0] pre_q;
   logic [11:0] pre_d;

   // Low bits that must all be ones for a tick
   function automatic logic [11:0] ratio_mask(input logic [2:0] sel);
      case (sel)
         3'h0:    ratio_mask = 12'h000;
         3'h1:    ratio_mask = 12'h003;
         3'h2:    ratio_mask = 12'h00f;
         3'h3:    ratio_mask = 12'h01f;
         3'h4:    ratio_mask = 12'h03f;
         3'h5:    ratio_mask = 12'h0ff;
         3'h6:    ratio_mask = 12'h3ff;
         default: ratio_mask = 12'hfff;
      endcase
   endfunction : ratio_mask

   always_comb begin
      pre_d = pre_q + 12'h001;
      // Mid-run select change may shorten one period
      tick  = ((pre_q & ratio_mask(select)) == ratio_mask(select));
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pre_q <= `WIT_PRE_RESET;
      end else begin
         pre_q <= pre_d;
      end
   end
endmodule : wit_prescaler

// *** rtl/wit_bus_port.sv ***
/*
   Peripheral bus port of the timer: keyed word writes, byte reads.
   Assumes one request per cycle held for one cycle by the processor side.
*/
module wit_bus_port
   import wit_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire wit_bus_req_type bus_req,
   input  wire logic [7:0]      count_val,
   input  wire logic [7:0]      csr_val,
   output logic                 wr_count_q,
   output logic                 wr_csr_q,
   output logic [7:0]           wr_data_q,
   output logic [7:0]           bus_rdata_q,
   output logic                 bus_ack_q
);
   import wit_pkg::*;

   logic       wr_count_d;
   logic       wr_csr_d;
   logic [7:0] wr_data_d;
   logic [7:0] bus_rdata_d;
   logic       is_word_write;

   always_comb begin
      is_word_write = bus_req.sel && bus_req.write && (bus_req.size == WIT_SIZE_WORD);
      wr_count_d    = 1'b0;
      wr_csr_d      = 1'b0;
      wr_data_d     = bus_req.wdata[7:0];
      bus_rdata_d   = 8'h00;
      if (is_word_write && (bus_req.addr == `WIT_ADDR_COUNT)
          && (bus_req.wdata[15:8] == `WIT_KEY_COUNT)) begin
         wr_count_d = 1'b1;
      end else if (is_word_write && (bus_req.addr == `WIT_ADDR_CSR)
                   && (bus_req.wdata[15:8] == `WIT_KEY_CSR)) begin
         wr_csr_d = 1'b1;
      end
      // Only byte reads return data; others read as zero
      if (bus_req.sel && !bus_req.write && (bus_req.size == WIT_SIZE_BYTE)) begin
         if (bus_req.addr == `WIT_ADDR_COUNT) begin
            bus_rdata_d = count_val;
         end else if (bus_req.addr == `WIT_ADDR_CSR) begin
            bus_rdata_d = csr_val;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_count_q  <= 1'b0;
         wr_csr_q    <= 1'b0;
         wr_data_q   <= 8'h00;
         bus_rdata_q <= 8'h00;
         bus_ack_q   <= 1'b0;
      end else begin
         wr_count_q  <= wr_count_d;
         wr_csr_q    <= wr_csr_d;
         wr_data_q   <= wr_data_d;
         bus_rdata_q <= bus_rdata_d;
         bus_ack_q   <= bus_req.sel;
      end
   end
endmodule : wit_bus_port

// *** test/wit_timer_sva.sv ***
/*
   Checker of the timer top: bus answers, overflow pulses, settling, clock pin.
   Assumes a bind to wit_timer; it sees that module's ports only.
*/
module wit_timer_sva
   import wit_pkg::*;
(
   input wire logic            clock,
   input wire logic            rst,
   input wire wit_bus_req_type bus_req,
   input wire logic [7:0]      bus_rdata,
   input wire logic            bus_ack,
   input wire logic [2:0]      clock_mode_pin,
   input wire logic            clock_out_enable,
   input wire logic            settle_req,
   input wire logic            clock_out_pin_o,
   input wire logic            clock_out_pin_oe_n,
   input wire logic            por_req,
   input wire logic            manual_req,
   input wire logic            interval_irq,
   input wire logic            clock_restart,
   input wire logic            internal_clock_stop
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // -----------------------------------------------------------------
   // Bus and overflow actions
   // -----------------------------------------------------------------
   chk_ack_follows: assert property (bus_req.sel |=> bus_ack)
      else $error("bus answer missing");
   chk_odd_read: assert property (bus_req.sel && !bus_req.write &&
      (bus_req.size != WIT_SIZE_BYTE || bus_req.addr[7:0] == 8'h88) |=> bus_rdata == 8'h00)
      else $error("odd read returned data");
   chk_one_action: assert property ($onehot0({interval_irq, por_req,
      manual_req, clock_restart})) else $error("two overflow actions at once");
   // An overflow needs 256 ticks, so a pulse never repeats at once
   chk_irq_single: assert property (interval_irq |=> !interval_irq)
      else $error("interval pulse too long");
   chk_reset_single: assert property ((por_req || manual_req) |=>
      !(por_req || manual_req)) else $error("reset pulse too long");

   // -----------------------------------------------------------------
   // Settling and clock pin
   // -----------------------------------------------------------------
   chk_settle_start: assert property (settle_req && !internal_clock_stop
      |=> internal_clock_stop) else $error("settling did not stop clock");
   chk_restart_end: assert property (clock_restart |->
      $past(internal_clock_stop) && !internal_clock_stop) else $error("restart out of place");
   chk_quiet_settle: assert property (internal_clock_stop |->
      !(interval_irq || por_req || manual_req)) else $error("action during settling");
   chk_pin_fixed: assert property ((clock_mode_pin == 3'h3 && !clock_out_enable)[*8]
      |-> !clock_out_pin_o && !clock_out_pin_oe_n) else $error("pin not fixed");
   chk_pin_toggle: assert property ((clock_mode_pin == 3'h3 && clock_out_enable)[*8]
      |-> clock_out_pin_o != $past(clock_out_pin_o)) else $error("pin not toggling");
   chk_pin_input: assert property ((clock_mode_pin == 3'h7)[*8]
      |-> clock_out_pin_oe_n) else $error("pin driven in input mode");

   cover property (interval_irq);
   cover property (por_req);
   cover property (manual_req);
   cover property (clock_restart);
endmodule : wit_timer_sva

// *** test/wit_cpu_model.sv ***
/*
   Processor side of the peripheral bus: one request at a time.
   Assumes the one-cycle request and one-cycle answer of the timer port.
*/
module wit_cpu_model
   import wit_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       bus_ack,
   input  wire logic [7:0] bus_rdata,
   output wit_bus_req_type bus_req
);
   timeunit 1ns;
   timeprecision 100ps;

   initial bus_req = '0;

   // Request is a one-cycle pulse; answer taken the cycle after
   task automatic access(input logic wr, input wit_size_type sz, input logic [31:0] ad,
                         input logic [15:0] wd, output logic [7:0] rd, output logic ak);
      @(posedge clock);
      #1;
      bus_req = '{sel: 1'b1, write: wr, size: sz, addr: ad, wdata: wd};
      @(posedge clock);
      #1;
      // Released lines show inverted values, except size, which keeps its stale value
      bus_req = '{sel: 1'b0, write: ~wr, size: sz, addr: ~ad, wdata: ~wd};
      ak = bus_ack;
      rd = bus_rdata;
   endtask : access
endmodule : wit_cpu_model

// *** test/test_wit_timer.sv ***
/*
   Self-checking bench of the timer top against a small integer model.
   Assumes the design, the checker and the bus model are compiled first.
*/
`include "wit_defines.svh"
module test_wit_timer
   import wit_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic            clock, rst, bus_ack, clock_out_enable, settle_req, ak, a;
   logic            clock_out_pin_o, clock_out_pin_oe_n, por_req, manual_req;
   logic            interval_irq, clock_restart, internal_clock_stop;
   logic [2:0]      clock_mode_pin;
   logic [7:0]      bus_rdata, rd;
   logic [31:0]     seed = 32'h1994406c;
   logic [31:0]     r;
   wit_bus_req_type bus_req;
   int              fails = 0;
   int              cmp_count = 0;
   int              m_cnt, m_csr, n, i;
   int              sh[$] = '{0, 2, 4, 5, 6, 8, 10, 12};
   wire [3:0]       pul = {clock_restart, manual_req, por_req, interval_irq};

   wit_timer uut (.clock, .rst, .bus_req, .bus_rdata, .bus_ack, .clock_mode_pin,
      .clock_out_enable, .settle_req, .clock_out_pin_i(1'b0), .clock_out_pin_o,
      .clock_out_pin_oe_n, .por_req, .manual_req, .interval_irq, .clock_restart,
      .internal_clock_stop);
   wit_cpu_model cpu (.clock, .bus_ack, .bus_rdata, .bus_req);

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      #500000;
      fails++;
      report_and_stop();
   end

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic note(input bit ok, input logic [31:0] g, e);
      cmp_count++;
      if (!ok) begin
         fails++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : note
   task automatic chk_reg(input logic [7:0] g, e);
      note(g === e, g, e);
   endtask : chk_reg
   task automatic chk_bit(input logic g, e);
      note(g === e, g, e);
   endtask : chk_bit
   task automatic chk_num(input int g, e);
      note(g == e, g, e);
   endtask : chk_num

   // Model takes only keyed word writes
   task automatic put(input wit_size_type sz, input logic [31:0] ad, input logic [15:0] wd);
      cpu.access(1'b1, sz, ad, wd, rd, ak);
      chk_bit(ak, 1'b1);
      if (sz == WIT_SIZE_WORD && ad == `WIT_ADDR_COUNT && wd[15:8] == `WIT_KEY_COUNT)
         m_cnt = wd[7:0];
      if (sz == WIT_SIZE_WORD && ad == `WIT_ADDR_CSR && wd[15:8] == `WIT_KEY_CSR)
         m_csr = wd[7:0];
   endtask : put
   task automatic rd_chk(input wit_size_type sz, input logic [31:0] ad, input logic [7:0] e);
      cpu.access(1'b0, sz, ad, 16'h0000, rd, ak);
      chk_bit(ak, 1'b1);
      chk_reg(rd, e);
   endtask : rd_chk
   task automatic wait_sig(input int w, lim);
      n = 0;
      while (pul[w] !== 1'b1 && n < lim) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk_bit(pul[w], 1'b1);
   endtask : wait_sig
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      clock_mode_pin = 3'h0;
      clock_out_enable = 1'b1;
      settle_req = 1'b0;
      m_cnt = 0;
      m_csr = 0;
      repeat (4) @(posedge clock);
      #1;
      rst = 1'b0;
      rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_COUNT, 8'h00);
      rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_CSR, 8'h00);
      put(WIT_SIZE_BYTE, `WIT_ADDR_COUNT, 16'h5a33);
      put(WIT_SIZE_LONG, `WIT_ADDR_CSR, 16'ha533);
      put(WIT_SIZE_WORD, `WIT_ADDR_COUNT, 16'ha533);
      put(WIT_SIZE_WORD, `WIT_ADDR_CSR, 16'h5a33);
      rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_COUNT, m_cnt[7:0]);
      rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_CSR, m_csr[7:0]);
      rd_chk(WIT_SIZE_WORD, `WIT_ADDR_COUNT, 8'h00);
      rd_chk(WIT_SIZE_BYTE, 32'hffffff88, 8'h00);
      for (i = 0; i < 4; i++) begin
         r = rnd();
         put(WIT_SIZE_WORD, `WIT_ADDR_COUNT, {`WIT_KEY_COUNT, r[7:0]});
         put(WIT_SIZE_WORD, `WIT_ADDR_CSR, {`WIT_KEY_CSR, 1'b0, r[14:8]});
         repeat (20) @(posedge clock);
         rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_COUNT, m_cnt[7:0]);
         rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_CSR, m_csr[7:0]);
      end
      // Period between two interrupts proves ratio and wrap-around
      for (i = 0; i < 5; i++) begin
         put(WIT_SIZE_WORD, `WIT_ADDR_CSR, {`WIT_KEY_CSR, 5'h00, i[2:0]});
         put(WIT_SIZE_WORD, `WIT_ADDR_COUNT, {`WIT_KEY_COUNT, 8'hfe});
         put(WIT_SIZE_WORD, `WIT_ADDR_CSR, {`WIT_KEY_CSR, 5'h10, i[2:0]});
         wait_sig(0, 20 << sh[i]);
         chk_bit(por_req | manual_req, 1'b0);
         @(posedge clock);
         #1;
         wait_sig(0, 300 << sh[i]);
         chk_num(n + 1, 256 << sh[i]);
         m_csr = m_csr | 8'h08;
         rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_CSR, m_csr[7:0]);
         put(WIT_SIZE_WORD, `WIT_ADDR_CSR, {`WIT_KEY_CSR, 5'h00, i[2:0]});
      end
      for (i = 0; i < 2; i++) begin
         put(WIT_SIZE_WORD, `WIT_ADDR_CSR, {`WIT_KEY_CSR, 2'b01, i[0], 5'h00});
         put(WIT_SIZE_WORD, `WIT_ADDR_COUNT, {`WIT_KEY_COUNT, 8'hfe});
         put(WIT_SIZE_WORD, `WIT_ADDR_CSR, {`WIT_KEY_CSR, 2'b11, i[0], 5'h00});
         wait_sig(1 + i, 20);
         chk_bit(interval_irq | pul[2 - i], 1'b0);
         m_csr = m_csr | 8'h10;
         rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_CSR, m_csr[7:0]);
         put(WIT_SIZE_WORD, `WIT_ADDR_CSR, {`WIT_KEY_CSR, 2'b01, i[0], 5'h00});
      end
      put(WIT_SIZE_WORD, `WIT_ADDR_CSR, {`WIT_KEY_CSR, 8'h02});
      put(WIT_SIZE_WORD, `WIT_ADDR_COUNT, {`WIT_KEY_COUNT, 8'hf8});
      @(posedge clock);
      #1;
      settle_req = 1'b1;
      @(posedge clock);
      #1;
      settle_req = 1'b0;
      chk_bit(internal_clock_stop, 1'b1);
      wait_sig(3, 400);
      chk_bit(internal_clock_stop, 1'b0);
      rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_CSR, m_csr[7:0]);
      rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_COUNT, 8'h00);
      clock_mode_pin = 3'h3;
      clock_out_enable = 1'b0;
      repeat (10) @(posedge clock);
      #1;
      chk_bit(clock_out_pin_o | clock_out_pin_oe_n, 1'b0);
      clock_out_enable = 1'b1;
      @(posedge clock);
      #1;
      a = clock_out_pin_o;
      @(posedge clock);
      #1;
      chk_bit(clock_out_pin_o, ~a);
      repeat (10) @(posedge clock);
      #1;
      clock_mode_pin = 3'h4;
      clock_out_enable = 1'b0;
      repeat (10) @(posedge clock);
      #1;
      chk_bit(clock_out_pin_o | clock_out_pin_oe_n, 1'b0);
      clock_out_enable = 1'b1;
      clock_mode_pin = 3'h7;
      repeat (10) @(posedge clock);
      #1;
      chk_bit(clock_out_pin_oe_n, 1'b1);
      // Pin reset in mid-run clears both registers again
      put(WIT_SIZE_WORD, `WIT_ADDR_COUNT, {`WIT_KEY_COUNT, 8'h77});
      rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_COUNT, m_cnt[7:0]);
      rst = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      rst = 1'b0;
      rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_COUNT, `WIT_COUNT_RESET);
      rd_chk(WIT_SIZE_BYTE, `WIT_ADDR_CSR, `WIT_CSR_RESET);
      report_and_stop();
   end
endmodule : test_wit_timer

bind wit_timer wit_timer_sva chk (.clock, .rst, .bus_req, .bus_rdata, .bus_ack,
   .clock_mode_pin, .clock_out_enable, .settle_req, .clock_out_pin_o, .clock_out_pin_oe_n,
   .por_req, .manual_req, .interval_irq, .clock_restart, .internal_clock_stop);
